// >>> src/hdp_pkg.sv
// Purpose: Shared constants and types for the host I/O mapped digital port block.
// Assumes: 10-bit host I/O address, 8-bit data, eight byte registers per board.
// Notes:   Offsets are byte offsets from the jumper-chosen base.
package hdp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int OFS_W = 3;
    localparam int IRQ_N = 4;
    localparam int JUMPER_N = 5;

    ////////////////////////////////////////////////////////////////////////////
    // Base address: root plus jumper code times the window size
    localparam logic [ADDR_W-1:0] BASE_ROOT = 10'h100;
    localparam int BASE_SHIFT = 3;

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [OFS_W-1:0] OFS_BOARD_IDENTIFIER = 3'h0;
    localparam logic [OFS_W-1:0] OFS_RESERVED_SLOT = 3'h1;
    localparam logic [OFS_W-1:0] OFS_JUMPER_STATE = 3'h2;
    localparam logic [OFS_W-1:0] OFS_INTERRUPT_ROUTING = 3'h3;
    localparam logic [OFS_W-1:0] OFS_PORT_DIRECTION = 3'h4;
    localparam logic [OFS_W-1:0] OFS_SINK_PORT_VALUE = 3'h5;
    localparam logic [OFS_W-1:0] OFS_SECOND_PORT_VALUE = 3'h6;
    localparam logic [OFS_W-1:0] OFS_THIRD_PORT_VALUE = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int DIR_THIRD_BIT = 0;
    localparam int DIR_SECOND_BIT = 1;
    localparam int ROUTE_LSB = 0;
    localparam int INVERT_LSB = 4;

    // Values after reset and fixed read values
    localparam logic [DATA_W-1:0] RESERVED_READ_VALUE = 8'h00;
    localparam logic [DATA_W-1:0] ROUTING_RESET = 8'h00;
    localparam logic [DATA_W-1:0] PORT_VALUE_RESET = 8'h00;
    localparam logic [DATA_W-1:0] SINK_ALL_ONES = 8'hFF;
    localparam logic [DATA_W-1:0] SINK_ALL_ZEROS = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b100
    } hdp_bus_state_t;

endpackage

// >>> src/hdp_port_if.sv
// Purpose: Carrier between the register file and one bidirectional byte port.
// Assumes: One clock domain; the register side owns direction and stored value.
// Notes:   level is what a data register read returns for this port.
`timescale 1ns/1ps
interface hdp_port_if;
    logic dir_out;
    logic [7:0] value;
    logic [7:0] level;

    modport ctrl (output dir_out, output value, input level);
    modport port (input dir_out, input value, output level);
endinterface

// >>> src/hdp_bidir_port.sv
// Purpose: One eight-line port that is either all inputs or all outputs.
// Assumes: Pin inputs are synchronous to i_clock.
// Notes:   Output enable is high while the port drives its lines.
`timescale 1ns/1ps
module hdp_bidir_port (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    hdp_port_if.port ctl,
    input wire logic [7:0] i_pin,
    output logic [7:0] o_pin,
    output logic [7:0] o_pin_oe,
    output logic [7:0] o_sampled
);

    logic [7:0] pin_r;
    logic [7:0] pin_nxt;
    logic [7:0] out_r;
    logic [7:0] out_nxt;
    logic [7:0] oe_r;
    logic [7:0] oe_nxt;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        pin_nxt = i_pin;
        out_nxt = ctl.value; // R14 R15
        oe_nxt = {8{ctl.dir_out}};
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            pin_r <= 8'h00;
            out_r <= 8'h00; // R16
            oe_r <= 8'h00;
        end else begin
            pin_r <= pin_nxt;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
        end
    end

    // Inputs read back the line levels, outputs the stored value
    assign ctl.level = ctl.dir_out ? ctl.value : pin_r; // R18
    assign o_pin = out_r;
    assign o_pin_oe = oe_r;
    assign o_sampled = pin_r;

endmodule

// >>> src/hdp_irq_route.sv
// Purpose: Routes low third-port lines onto host interrupt lines with inversion.
// Assumes: Source levels are already registered in the clock domain.
// Notes:   An unrouted interrupt line is left undriven for other boards.
`timescale 1ns/1ps
module hdp_irq_route #(
    parameter int IRQ_N = hdp_pkg::IRQ_N
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic [IRQ_N-1:0] i_source,
    input wire logic [IRQ_N-1:0] i_route,
    input wire logic [IRQ_N-1:0] i_invert,
    output logic [IRQ_N-1:0] o_irq,
    output logic [IRQ_N-1:0] o_irq_oe
);

    logic [IRQ_N-1:0] irq_r;
    logic [IRQ_N-1:0] irq_nxt;
    logic [IRQ_N-1:0] oe_r;
    logic [IRQ_N-1:0] oe_nxt;

    ////////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < IRQ_N; g++) begin : g_line
            always_comb begin
                irq_nxt[g] = i_source[g] ^ i_invert[g]; // R6
                oe_nxt[g] = i_route[g]; // R5
            end
        end
    endgenerate

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            irq_r <= '0;
            oe_r <= '0;
        end else begin
            irq_r <= irq_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign o_irq = irq_r;
    assign o_irq_oe = oe_r;

endmodule

// >>> src/hdp_top.sv
// Purpose: Host I/O mapped digital port block: eight byte registers, three ports.
// Assumes: Host strobes, address and data are synchronous to i_clock.
// Notes:   Writes commit when the write strobe ends; reads drive data while the
//          read strobe is low and the address decodes to this board.
//          Read wins when both strobes are low in one idle cycle.
//          Cycles with address enable high are never decoded.
//
// Notes on behaviour
// [R1] Eight byte registers in host I/O space at a jumper-chosen base.
// [R2] Base jumpers select 0x100, 0x108, 0x110 or 0x118.
// [R3] Offset zero reads a fixed board identifier; writes do nothing.
// [R4] Jumper status bits 0-4 show the five jumpers, 1 when fitted.
// [R5] Routing bits 0-3 connect third port lines 0-3 to four interrupt lines.
// [R6] Bits 4-7 invert those interrupt lines; register is read and write.
// [R7] Direction bit 0 sets third port, bit 1 second port; 1 means outputs.
// [R8] Direction bits 2-7 are reserved with no function.
// [R9] Direction bits load from the two direction jumpers at reset.
// [R10] Direction jumper off gives inputs, on gives outputs, per port.
// [R11] A host write to direction overrides the jumpers until next reset.
// [R12] Sink port register bits drive its eight lines; read and write.
// [R13] Sink port is always output, never turned to inputs.
// [R14] Second port register bits map one to one onto its lines.
// [R15] Third port register bits map one to one onto its lines.
// [R16] After reset, second and third port outputs drive zero.
// [R17] After reset, sink port lines all zero or all one by jumper.
// [R18] Input port data reads return line levels; writes only store value.
// [R19] Reserved offset one reads a fixed value; writes are ignored.
`timescale 1ns/1ps
module hdp_top #(
    parameter logic [7:0] BOARD_ID = 8'hA5 // Arbitrary identifier value
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    // Host bus side
    input wire logic [9:0] i_addr,
    input wire logic i_aen,
    input wire logic i_ior_n,
    input wire logic i_iow_n,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe,
    // Board jumpers, high when fitted
    input wire logic i_base_select_low_jumper,
    input wire logic i_base_select_high_jumper,
    input wire logic i_third_port_dir_jumper,
    input wire logic i_second_port_dir_jumper,
    input wire logic i_sink_port_reset_jumper,
    // Connector lines
    output logic [7:0] o_sink_port,
    input wire logic [7:0] i_second_port,
    output logic [7:0] o_second_port,
    output logic [7:0] o_second_port_oe,
    input wire logic [7:0] i_third_port,
    output logic [7:0] o_third_port,
    output logic [7:0] o_third_port_oe,
    // Host interrupt lines, driven only while enabled
    output logic [3:0] o_irq,
    output logic [3:0] o_irq_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Base address from the two select jumpers
    function automatic logic [9:0] base_of(
        input logic jp_low,
        input logic jp_high
    );
        logic [9:0] code;
        code = {8'h00, jp_high, jp_low};
        return hdp_pkg::BASE_ROOT | (code << hdp_pkg::BASE_SHIFT); // R2
    endfunction

    // True when a host address falls in this board's eight-byte window
    function automatic logic hits(
        input logic [9:0] addr,
        input logic [9:0] base,
        input logic aen
    );
        return !aen && (addr[9:3] == base[9:3]); // R1
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register state

    // Bus cycle capture
    hdp_pkg::hdp_bus_state_t state_r;
    hdp_pkg::hdp_bus_state_t state_nxt;
    logic [2:0] ofs_r;
    logic [2:0] ofs_nxt;
    logic [7:0] wdata_r;
    logic [7:0] wdata_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // Registers the host can write
    logic [7:0] routing_r;
    logic [7:0] routing_nxt;
    logic [1:0] dir_r;
    logic [1:0] dir_nxt;
    logic [7:0] sink_r;
    logic [7:0] sink_nxt;
    logic [7:0] second_r;
    logic [7:0] second_nxt;
    logic [7:0] third_r;
    logic [7:0] third_nxt;

    // Decode results and port taps
    logic [9:0] base;
    logic hit;
    logic commit;
    logic [4:0] jumpers;
    logic [7:0] third_sampled;

    // One carrier per bidirectional port
    hdp_port_if second_if ();
    hdp_port_if third_if ();

    // Decode follows the jumpers live; move them
    // only while the host bus is idle
    assign base = base_of(i_base_select_low_jumper, i_base_select_high_jumper);
    assign hit = hits(i_addr, base, i_aen);
    assign jumpers = { // R4
        i_sink_port_reset_jumper,
        i_second_port_dir_jumper,
        i_third_port_dir_jumper,
        i_base_select_high_jumper,
        i_base_select_low_jumper
    };

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer

    function automatic logic [7:0] read_mux(
        input logic [2:0] ofs,
        input logic [4:0] jp,
        input logic [7:0] routing,
        input logic [1:0] dir,
        input logic [7:0] sink,
        input logic [7:0] second_lvl,
        input logic [7:0] third_lvl
    );
        logic [7:0] v;
        v = 8'h00;
        unique case (ofs)
            hdp_pkg::OFS_BOARD_IDENTIFIER: v = BOARD_ID; // R3
            hdp_pkg::OFS_RESERVED_SLOT: v = hdp_pkg::RESERVED_READ_VALUE; // R19
            hdp_pkg::OFS_JUMPER_STATE: v = {3'h0, jp}; // R4
            hdp_pkg::OFS_INTERRUPT_ROUTING: v = routing; // R6
            hdp_pkg::OFS_PORT_DIRECTION: v = {6'h00, dir}; // R8
            hdp_pkg::OFS_SINK_PORT_VALUE: v = sink; // R12
            hdp_pkg::OFS_SECOND_PORT_VALUE: v = second_lvl; // R18
            hdp_pkg::OFS_THIRD_PORT_VALUE: v = third_lvl; // R18
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Host bus cycle tracking
    // Write data is taken on every strobe-low cycle so the last, settled value
    // is the one committed when the strobe rises.
    // Read data is refreshed every cycle of a read, and an input
    // port read lags its lines by two cycles (pin sample, then read data).

    always_comb begin
        state_nxt = state_r;
        ofs_nxt = ofs_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        commit = 1'b0;

        unique case (state_r)
            hdp_pkg::ST_IDLE: begin
                // Read is tested first, so it wins
                if (!i_ior_n && hit) begin
                    state_nxt = hdp_pkg::ST_READ;
                    ofs_nxt = i_addr[2:0];
                    rdata_nxt = read_mux(
                        i_addr[2:0],
                        jumpers,
                        routing_r,
                        dir_r,
                        sink_r,
                        second_if.level,
                        third_if.level
                    );
                end else if (!i_iow_n && hit) begin
                    state_nxt = hdp_pkg::ST_WRITE;
                    ofs_nxt = i_addr[2:0];
                    wdata_nxt = i_data;
                end
            end
            hdp_pkg::ST_READ: begin
                // Keep following live levels while the strobe is held
                rdata_nxt = read_mux(
                    ofs_r,
                    jumpers,
                    routing_r,
                    dir_r,
                    sink_r,
                    second_if.level,
                    third_if.level
                );
                // Bus is released one cycle after the strobe rises
                if (i_ior_n) begin
                    state_nxt = hdp_pkg::ST_IDLE;
                end
            end
            hdp_pkg::ST_WRITE: begin
                // Commit in the first cycle that sees the strobe high
                if (i_iow_n) begin
                    state_nxt = hdp_pkg::ST_IDLE;
                    commit = 1'b1;
                end else begin
                    wdata_nxt = i_data;
                end
            end
            default: begin
                // An illegal one-hot code falls back to idle
                state_nxt = hdp_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            state_r <= hdp_pkg::ST_IDLE;
            ofs_r <= 3'h0;
            wdata_r <= 8'h00;
            rdata_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            ofs_r <= ofs_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and data registers
    // Reset is synchronous, so jumper levels can be loaded on it directly.

    always_comb begin
        routing_nxt = routing_r;
        dir_nxt = dir_r;
        sink_nxt = sink_r;
        second_nxt = second_r;
        third_nxt = third_r;

        if (commit) begin
            unique case (ofs_r)
                hdp_pkg::OFS_INTERRUPT_ROUTING: routing_nxt = wdata_r; // R5 R6
                hdp_pkg::OFS_PORT_DIRECTION: begin
                    // Spare bits are not stored, so they read as zero
                    dir_nxt[hdp_pkg::DIR_THIRD_BIT] = wdata_r[hdp_pkg::DIR_THIRD_BIT]; // R11
                    dir_nxt[hdp_pkg::DIR_SECOND_BIT] = wdata_r[hdp_pkg::DIR_SECOND_BIT]; // R11
                end
                hdp_pkg::OFS_SINK_PORT_VALUE: sink_nxt = wdata_r; // R12
                hdp_pkg::OFS_SECOND_PORT_VALUE: second_nxt = wdata_r; // R14 R18
                hdp_pkg::OFS_THIRD_PORT_VALUE: third_nxt = wdata_r; // R15 R18
                // Identifier, reserved slot and jumper state ignore writes
                default: begin
                end // R3 R19
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            routing_r <= hdp_pkg::ROUTING_RESET;
            dir_r[hdp_pkg::DIR_THIRD_BIT] <= i_third_port_dir_jumper; // R9 R10
            dir_r[hdp_pkg::DIR_SECOND_BIT] <= i_second_port_dir_jumper; // R9 R10
            if (i_sink_port_reset_jumper) begin
                sink_r <= hdp_pkg::SINK_ALL_ONES; // R17
            end else begin
                sink_r <= hdp_pkg::SINK_ALL_ZEROS; // R17
            end
            second_r <= hdp_pkg::PORT_VALUE_RESET; // R16
            third_r <= hdp_pkg::PORT_VALUE_RESET; // R16
        end else begin
            routing_r <= routing_nxt;
            dir_r <= dir_nxt;
            sink_r <= sink_nxt;
            second_r <= second_nxt;
            third_r <= third_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ports
    // Port modules register direction and value, so
    // the lines move one cycle after the register.

    assign second_if.dir_out = dir_r[hdp_pkg::DIR_SECOND_BIT]; // R7
    assign second_if.value = second_r;
    assign third_if.dir_out = dir_r[hdp_pkg::DIR_THIRD_BIT]; // R7
    assign third_if.value = third_r;

    // Second port
    hdp_bidir_port u_second (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .ctl(second_if),
        .i_pin(i_second_port),
        .o_pin(o_second_port),
        .o_pin_oe(o_second_port_oe),
        .o_sampled()
    );

    // Third port; low lines also feed the interrupts
    hdp_bidir_port u_third (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .ctl(third_if),
        .i_pin(i_third_port),
        .o_pin(o_third_port),
        .o_pin_oe(o_third_port_oe),
        .o_sampled(third_sampled)
    );

    // Interrupt sources are the sampled line levels, so an output port can
    // still raise an interrupt from its own driven value
    hdp_irq_route #(
        .IRQ_N(hdp_pkg::IRQ_N)
    ) u_irq (
        .i_clock(i_clock),
        .i_sys_rst(i_sys_rst),
        .i_source(third_sampled[hdp_pkg::IRQ_N-1:0]),
        .i_route(routing_r[hdp_pkg::ROUTE_LSB +: hdp_pkg::IRQ_N]),
        .i_invert(routing_r[hdp_pkg::INVERT_LSB +: hdp_pkg::IRQ_N]),
        .o_irq(o_irq),
        .o_irq_oe(o_irq_oe)
    );

    // Sink port has no direction control at all
    assign o_sink_port = sink_r; // R13

    ////////////////////////////////////////////////////////////////////////////
    // Host data bus

    assign o_data = rdata_r;
    assign o_data_oe = (state_r == hdp_pkg::ST_READ);

endmodule

// >>> sim/hdp_top_checker.sv
// Purpose: Concurrent checks on the host register bus and port pins of hdp_top.
// Assumes: Single clock domain, synchronous active-high reset.
// Notes:   Jumper inputs are held stable by the bench across a reset release.
`timescale 1ns/1ps
module hdp_top_checker #(
    parameter logic [7:0] BOARD_ID = 8'hA5
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic [9:0] i_addr,
    input wire logic i_aen,
    input wire logic i_ior_n,
    input wire logic [7:0] o_data,
    input wire logic o_data_oe,
    input wire logic i_base_select_low_jumper,
    input wire logic i_base_select_high_jumper,
    input wire logic i_third_port_dir_jumper,
    input wire logic i_second_port_dir_jumper,
    input wire logic i_sink_port_reset_jumper,
    input wire logic [7:0] o_sink_port,
    input wire logic [7:0] o_second_port_oe,
    input wire logic [7:0] o_third_port_oe,
    input wire logic [3:0] o_irq_oe
);
    logic hit;
    logic [6:0] base_hi;

    assign base_hi = {5'b01000, i_base_select_high_jumper, i_base_select_low_jumper};
    assign hit = !i_ior_n && !i_aen && i_addr[9:3] == base_hi;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);

    ////////////////////////////////////////////////////////////////////////////
    AST_READ_TAKE:
        assert property ($fell(i_ior_n) && hit |-> ##[1:2] o_data_oe) else $error("read hit not answered");
    AST_NO_FOREIGN:
        assert property ($rose(o_data_oe) |-> $past(hit)) else $error("bus driven without a hit");
    AST_READ_HOLD:
        assert property (o_data_oe && !i_ior_n |=> o_data_oe) else $error("read data dropped early");
    AST_READ_END:
        assert property (o_data_oe && i_ior_n |=> !o_data_oe) else $error("read data held too long");
    AST_ID_VALUE:
        assert property (o_data_oe && !i_ior_n && i_addr[2:0] == 3'h0 |-> o_data == BOARD_ID)
        else $error("identifier wrong");
    AST_RSVD_VALUE:
        assert property (o_data_oe && !i_ior_n && i_addr[2:0] == 3'h1 |-> o_data == 8'h00)
        else $error("reserved slot not zero");
    AST_JUMPER_VALUE:
        assert property (o_data_oe && !i_ior_n && i_addr[2:0] == 3'h2 |-> o_data == {3'h0,
            i_sink_port_reset_jumper, i_second_port_dir_jumper, i_third_port_dir_jumper, base_hi[1:0]})
        else $error("jumper state wrong");
    AST_DIR_UNUSED:
        assert property (o_data_oe && !i_ior_n && i_addr[2:0] == 3'h4 |-> o_data[7:2] == 6'h00)
        else $error("direction spare bits set");
    AST_SINK_RESET:
        assert property ($fell(i_sys_rst) |-> o_sink_port == {8{i_sink_port_reset_jumper}} && !o_data_oe
            && o_irq_oe == 4'h0) else $error("reset levels wrong");
    AST_PORT_RESET:
        assert property ($fell(i_sys_rst) |=> o_second_port_oe == {8{i_second_port_dir_jumper}}
            && o_third_port_oe == {8{i_third_port_dir_jumper}}) else $error("reset direction wrong");
    AST_OE_WHOLE:
        assert property (o_second_port_oe == 8'h00 || o_second_port_oe == 8'hFF) else $error("split direction");
endmodule

bind hdp_top hdp_top_checker #(.BOARD_ID(BOARD_ID)) hdp_top_checker_i (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_aen(i_aen), .i_ior_n(i_ior_n),
    .o_data(o_data), .o_data_oe(o_data_oe), .i_base_select_low_jumper(i_base_select_low_jumper),
    .i_base_select_high_jumper(i_base_select_high_jumper), .i_third_port_dir_jumper(i_third_port_dir_jumper),
    .i_second_port_dir_jumper(i_second_port_dir_jumper), .i_sink_port_reset_jumper(i_sink_port_reset_jumper),
    .o_sink_port(o_sink_port), .o_second_port_oe(o_second_port_oe), .o_third_port_oe(o_third_port_oe),
    .o_irq_oe(o_irq_oe)
);

// >>> sim/hdp_pin_env.sv
// Purpose: Connector-side model of one bidirectional byte port.
// Assumes: External source drives all eight lines or none.
// Notes:   Undriven lines read high, as the lines carry pull-ups.
`timescale 1ns/1ps
module hdp_pin_env (
    input wire logic [7:0] i_drive,
    input wire logic [7:0] i_drive_oe,
    input wire logic [7:0] i_ext,
    input wire logic i_ext_en,
    output logic [7:0] o_level
);
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            o_level[b] = i_drive_oe[b] ? i_drive[b] : (i_ext_en ? i_ext[b] : 1'b1);
        end
    end
endmodule

// >>> sim/hdp_top_tb_top.sv
// Purpose: Self-checking bench for hdp_top over the host strobe bus.
// Assumes: Inputs change on the falling edge; one access at a time.
// Notes:   Reads queue their expected byte; a monitor compares on answer.
`timescale 1ns/1ps
module hdp_top_tb_top;
    localparam logic [7:0] ID_CODE = 8'h3C; // Arbitrary identifier value
    logic i_clock = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [9:0] addr = 10'h000;
    logic aen = 1'b0, ior_n = 1'b1, iow_n = 1'b1, ext_en = 1'b0, seen = 1'b0;
    logic [7:0] wdata = 8'h00, ext2 = 8'h00, ext3 = 8'h00, v = 8'h00, r = 8'h00;
    logic [4:0] jp = 5'h00;
    logic [9:0] base = 10'h100;
    logic [7:0] o_data, oe2, oe3, out2, out3, lvl2, lvl3, sink;
    logic o_data_oe;
    logic [3:0] irq, irq_oe;
    logic [7:0] exp_q[$];
    int fails = 0, total_checks = 0, cycles = 0, seed = 37219;

    always #25 i_clock = ~i_clock;

    hdp_top #(.BOARD_ID(ID_CODE)) hdp_top_i (
        .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(addr), .i_aen(aen), .i_ior_n(ior_n),
        .i_iow_n(iow_n), .i_data(wdata), .o_data(o_data), .o_data_oe(o_data_oe),
        .i_base_select_low_jumper(jp[0]), .i_base_select_high_jumper(jp[1]), .i_third_port_dir_jumper(jp[2]),
        .i_second_port_dir_jumper(jp[3]), .i_sink_port_reset_jumper(jp[4]), .o_sink_port(sink),
        .i_second_port(lvl2), .o_second_port(out2), .o_second_port_oe(oe2), .i_third_port(lvl3),
        .o_third_port(out3), .o_third_port_oe(oe3), .o_irq(irq), .o_irq_oe(irq_oe)
    );
    hdp_pin_env hdp_pin_env_second_i (.i_drive(out2), .i_drive_oe(oe2), .i_ext(ext2), .i_ext_en(ext_en),
        .o_level(lvl2));
    hdp_pin_env hdp_pin_env_third_i (.i_drive(out3), .i_drive_oe(oe3), .i_ext(ext3), .i_ext_en(ext_en),
        .o_level(lvl3));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        check_val(8'(exp_q.size()), 8'h00);
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hold the strobe three cycles so the answer is seen before release
    task automatic rd_at(input logic [9:0] a, input logic [7:0] exp, input logic hit);
        @(negedge i_clock);
        if (hit) begin
            exp_q.push_back(exp);
        end
        addr = a;
        ior_n = 1'b0;
        repeat (3) @(negedge i_clock);
        ior_n = 1'b1;
        repeat (2) @(negedge i_clock);
    endtask

    task automatic rd(input logic [2:0] ofs, input logic [7:0] exp);
        rd_at({base[9:3], ofs}, exp, 1'b1);
    endtask

    // Pins settle by the edge after the one that sees the strobe high
    task automatic wr(input logic [2:0] ofs, input logic [7:0] d);
        @(negedge i_clock);
        addr = {base[9:3], ofs};
        wdata = d;
        iow_n = 1'b0;
        @(negedge i_clock);
        iow_n = 1'b1;
        repeat (4) @(negedge i_clock);
    endtask

    task automatic do_reset();
        @(negedge i_clock);
        i_sys_rst = 1'b1;
        repeat (2) @(negedge i_clock);
        i_sys_rst = 1'b0;
        repeat (2) @(negedge i_clock);
    endtask

    always @(negedge i_clock) begin
        if (o_data_oe === 1'b1 && !seen) begin
            if (exp_q.size() == 0) begin
                check_val({7'h00, o_data_oe}, 8'h00);
            end else begin
                check_val(o_data, exp_q.pop_front());
            end
        end
        seen = (o_data_oe === 1'b1);
    end

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int k = 0; k < 4; k++) begin
            jp = {k[1] ^ k[0], k[0], k[1], k[1:0]};
            base = {5'b01000, jp[1:0], 3'b000};
            do_reset();
            check_val(sink, {8{jp[4]}});
            check_val(oe2, {8{jp[3]}});
            check_val(oe3, {8{jp[2]}});
            check_val(out2 & oe2, 8'h00);
            check_val(out3 & oe3, 8'h00);
            rd(3'h0, ID_CODE);
            rd(3'h2, {3'h0, jp});
            rd(3'h4, {6'h00, jp[3], jp[2]});
            rd(3'h1, 8'h00);
            rd(3'h3, 8'h00);
            rd_at(base ^ 10'h008, 8'h00, 1'b0);
            aen = 1'b1;
            rd_at(base, 8'h00, 1'b0);
            aen = 1'b0;
        end
        for (int n = 0; n < 4; n++) begin
            v = 8'($random(seed));
            wr(3'h5, v);
            check_val(sink, v);
            rd(3'h5, v);
            wr(3'h6, ~v);
            check_val(out2, ~v);
            rd(3'h6, ~v);
            wr(3'h7, v ^ 8'h5A);
            check_val(out3, v ^ 8'h5A);
            wr(3'h0, v);
            rd(3'h0, ID_CODE);
            wr(3'h1, v);
            rd(3'h1, 8'h00);
            wr(3'h2, v);
            rd(3'h2, {3'h0, jp});
        end
        wr(3'h4, 8'hFC);
        rd(3'h4, 8'h00);
        check_val(oe2 | oe3, 8'h00);
        check_val(sink, v);
        ext_en = 1'b1;
        for (int n = 0; n < 4; n++) begin
            ext2 = 8'($random(seed));
            ext3 = 8'($random(seed));
            r = 8'($random(seed));
            wr(3'h6, ext3);
            check_val(oe2, 8'h00);
            rd(3'h6, ext2);
            rd(3'h7, ext3);
            wr(3'h3, r);
            rd(3'h3, r);
            check_val({4'h0, irq_oe}, {4'h0, r[3:0]});
            check_val({4'h0, irq & r[3:0]}, {4'h0, (ext3[3:0] ^ r[7:4]) & r[3:0]});
        end
        wr(3'h4, 8'h02);
        check_val(oe2, 8'hFF);
        check_val(out2, ext3);
        check_val(oe3, 8'h00);
        wr(3'h4, 8'h01);
        check_val(oe3, 8'hFF);
        check_val(oe2, 8'h00);
        ext_en = 1'b0;
        wr(3'h4, 8'h00);
        rd(3'h6, 8'hFF);
        do_reset();
        rd(3'h4, 8'h03);
        conclude();
    end
endmodule
